// ---- dv/dmsc_host_model.sv ----
// Host side of the three-wire port: shifts one word per call.
// Assumes i_clk at 40 ns; serial clock period is eight i_clk.
`timescale 1ns/1ps
module dmsc_host_model (
    input  wire i_clk,
    output reg  o_sclk,
    output reg  o_cs_n,
    output reg  o_sdin
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdin = 1'b0;
    end
    task send(input [6:0] w);
        integer i;
        begin
            @(posedge i_clk); #2 o_cs_n = 1'b0;
            for (i = 6; i >= 0; i = i - 1) begin
                o_sdin = w[i];
                repeat (4) @(posedge i_clk); #2 o_sclk = 1'b1;
                repeat (4) @(posedge i_clk); #2 o_sclk = 1'b0;
            end
            repeat (4) @(posedge i_clk); #2 o_cs_n = 1'b1;
            o_sdin = ~o_sdin;
        end
    endtask
endmodule // dmsc_host_model

// ---- dv/dmsc_properties.sv ----
// Checker for the serial mode control block.
// Assumes binding to dmsc_serial_ctrl; sees its ports only.
`timescale 1ns/1ps
module dmsc_properties (
    input wire       i_clk, i_rst_n, i_cs_n,
    input wire [4:0] o_chan_one_mode, o_chan_two_mode,
    input wire [5:0] o_drive_state,
    input wire [3:0] o_slew_select,
    input wire [1:0] o_load_on, o_clamp_on, o_comp_on
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_leak_one: assert property (o_chan_one_mode[4] |->
        o_drive_state[2:0] == 3'h4 && !o_load_on[0] && !o_clamp_on[0]) else $error("ch1 leak");
    chk_leak_two: assert property (o_chan_two_mode[4] |->
        o_drive_state[5:3] == 3'h4 && !o_load_on[1] && !o_clamp_on[1]) else $error("ch2 leak");
    chk_cal_load: assert property (!o_chan_one_mode[4] && o_chan_one_mode[0] |->
        o_load_on[0]) else $error("cal load off");
    chk_slew_copy: assert property (o_slew_select ==
        {o_chan_two_mode[2:1], o_chan_one_mode[2:1]}) else $error("slew mismatch");
    chk_term_cause: assert property (o_drive_state[5:3] == 3'h2 |->
        o_chan_two_mode[4:3] == 2'h1) else $error("term without select");
    chk_clamp_hiz: assert property (o_clamp_on[1] |->
        o_drive_state[5:3] == 3'h3) else $error("clamp outside hiz");
    chk_comp_alive: assert property ($past(i_rst_n) |->
        o_comp_on == 2'h3) else $error("comparators off");
    chk_mode_cause: assert property (!$stable({o_chan_one_mode, o_chan_two_mode}) |->
        $past(i_cs_n, 3) && !$past(i_cs_n, 7)) else $error("mode change without select rise");
endmodule // dmsc_properties
bind dmsc_serial_ctrl dmsc_properties u_dmsc_properties (.*);

// ---- dv/dmsc_serial_ctrl_bench.sv ----
// Bench: writes mode words and checks latches and decoded outputs.
// Assumes data and load inputs held steady; receive select changes once, before the last decode check.
`timescale 1ns/1ps
module dmsc_serial_ctrl_bench;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    wire       sclk, cs_n, sdin;
    wire [4:0] m1, m2;
    wire [5:0] drv;
    wire [3:0] slw;
    wire [1:0] ld, cl, cp;
    reg  [1:0] dat = 2'h1;
    reg  [1:0] rcv = 2'h2;
    reg  [1:0] load_enable_in = 2'h1;
    integer    errors = 0;
    integer    check_count = 0;
    dmsc_host_model u_dmsc_host_model (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdin(sdin));
    dmsc_serial_ctrl u_dmsc_serial_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdin(sdin), .i_data_in(dat), .i_receive_select_in(rcv),
        .i_load_enable_in(load_enable_in), .o_chan_one_mode(m1), .o_chan_two_mode(m2),
        .o_drive_state(drv), .o_slew_select(slw), .o_load_on(ld), .o_clamp_on(cl),
        .o_comp_on(cp));
    initial forever #20 clk = ~clk;
    task cmp(input [23:0] e);
        begin
            check_count = check_count + 1;
            if ({m1, m2, drv, ld, cl, slw} !== e) begin
                errors = errors + 1;
                $display("unexpected %0t state %h", $time, {m1, m2, drv, ld, cl, slw});
            end
        end
    endtask
    task cmp_comp(input [1:0] e);
        begin
            check_count = check_count + 1;
            if (cp !== e) begin
                errors = errors + 1;
                $display("unexpected %0t comparators %h", $time, cp);
            end
        end
    endtask
    task step(input [6:0] w, input [23:0] e);
        begin
            u_dmsc_host_model.send(w);
            repeat (8) @(posedge clk);
            #2 cmp(e);
        end
    endtask
    task summarize;
        begin
            $display("errors %0d checks %0d", errors, check_count);
            if (errors == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk); #2 rst_n = 1'b1;
        repeat (4) @(posedge clk); #2 cmp(24'h842400);
        cmp_comp(2'h3);
        step(7'h4A, 24'h542141);
        step(7'h27, 24'h51D9ED);
        step(7'h1F, 24'h51D9ED);
        step(7'h71, 24'h8C6400);
        cmp_comp(2'h3);
        step(7'h45, 24'h2C6142);
        step(7'h28, 24'h2A1142);
        @(posedge clk); #2 rcv = 2'h1;
        repeat (8) @(posedge clk); #2 cmp(24'h2A0352);
        @(posedge clk); #2 rst_n = 1'b0;
        repeat (4) @(posedge clk); #2 rst_n = 1'b1;
        repeat (3) @(posedge clk); #2 cmp(24'h842400);
        summarize;
    end
endmodule // dmsc_serial_ctrl_bench

// ---- logic/dmsc_map.vh ----
// Constants for the dual channel mode serial control block.
// Assumes inclusion by bare name from the design file.
`ifndef DMSC_MAP_VH
`define DMSC_MAP_VH

// Serial word layout
`define DMSC_WORD_W       7
`define DMSC_MODE_W       5
`define DMSC_BIT_CH1_EN   6
`define DMSC_BIT_CH2_EN   5
`define DMSC_BIT_LOW_LEAK_SELECT    4
`define DMSC_BIT_TERM     3
`define DMSC_BIT_SLEW_HI  2
`define DMSC_BIT_SLEW_LO  1
`define DMSC_BIT_LOAD_CAL_FORCE    0
`define DMSC_DRV_W        3
`define DMSC_SLEW_W       2
`define DMSC_SYNC_W       9

// Synchroniser reset: chip select idle high, serial clock idle low
`define DMSC_SYNC_RST     9'h002
`define DMSC_FLAGS_OFF    2'h0
`define DMSC_COMP_ON      2'h3

// Mode latch reset value: low leakage set, all else clear
`define DMSC_MODE_RST     5'h10
`define DMSC_WORD_RST     7'h00

// Slew codes
`define DMSC_SLEW_100     2'h0
`define DMSC_SLEW_75      2'h1
`define DMSC_SLEW_50      2'h2
`define DMSC_SLEW_25      2'h3

// Driver output state codes
`define DMSC_DRV_LOW      3'h0
`define DMSC_DRV_HIGH     3'h1
`define DMSC_DRV_TERM     3'h2
`define DMSC_DRV_HIZ      3'h3
`define DMSC_DRV_LOW_LEAK_SELECT    3'h4

`endif

// ---- logic/dmsc_serial_ctrl.v ----
// Serial control port and per-channel mode latches of a dual pin driver.
// Assumes serial pins and high-speed inputs are asynchronous to i_clk;
// the serial clock is far slower than i_clk (at least 4 samples per phase).
`timescale 1ns/1ps
`include "dmsc_map.vh"

module dmsc_serial_ctrl (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_sclk,
    input  wire        i_cs_n,
    input  wire        i_sdin,
    input  wire [1:0]  i_data_in,
    input  wire [1:0]  i_receive_select_in,
    input  wire [1:0]  i_load_enable_in,
    output reg  [4:0]  o_chan_one_mode,
    output reg  [4:0]  o_chan_two_mode,
    output reg  [5:0]  o_drive_state,
    output reg  [3:0]  o_slew_select,
    output reg  [1:0]  o_load_on,
    output reg  [1:0]  o_clamp_on,
    output reg  [1:0]  o_comp_on
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg  [`DMSC_SYNC_W-1:0]  sync1_reg;
    reg  [`DMSC_SYNC_W-1:0]  sync2_reg;
    reg         sclk_d_reg;
    reg         cs_d_reg;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_reg  <= `DMSC_SYNC_RST;
            sync2_reg  <= `DMSC_SYNC_RST;
            sclk_d_reg <= 1'b0;
            cs_d_reg   <= 1'b1;
        end else begin
            sync1_reg  <= {i_load_enable_in, i_receive_select_in, i_data_in,
                           i_sdin, i_cs_n, i_sclk};
            sync2_reg  <= sync1_reg;
            sclk_d_reg <= sync2_reg[0];
            cs_d_reg   <= sync2_reg[1];
        end
    end

    wire        sclk_s  = sync2_reg[0];
    wire        cs_n_s  = sync2_reg[1];
    wire        sdin_s  = sync2_reg[2];
    wire [1:0]  data_s  = sync2_reg[4:3];
    wire [1:0]  rcv_s   = sync2_reg[6:5];
    wire [1:0]  load_enable_in_s  = sync2_reg[8:7];
    wire        sclk_rise = sclk_s & ~sclk_d_reg;
    wire        cs_rise   = cs_n_s & ~cs_d_reg;

    // ****************************************
    // Shift register and mode latches
    // ****************************************
    reg  [`DMSC_WORD_W-1:0]  shift_reg;
    reg  [`DMSC_WORD_W-1:0]  shift_next;
    reg  [`DMSC_MODE_W-1:0]  mode1_reg;
    reg  [`DMSC_MODE_W-1:0]  mode2_reg;

    always @* begin
        shift_next = shift_reg;
        if (!cs_n_s && sclk_rise)
            shift_next = {shift_reg[`DMSC_WORD_W-2:0], sdin_s};
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            shift_reg <= `DMSC_WORD_RST;
            mode1_reg <= `DMSC_MODE_RST;
            mode2_reg <= `DMSC_MODE_RST;
        end else begin
            shift_reg <= shift_next;
            if (cs_rise) begin
                if (shift_reg[`DMSC_BIT_CH1_EN])
                    mode1_reg <= shift_reg[`DMSC_MODE_W-1:0];
                if (shift_reg[`DMSC_BIT_CH2_EN])
                    mode2_reg <= shift_reg[`DMSC_MODE_W-1:0];
            end
        end
    end

    // ****************************************
    // Per-channel mode decode
    // ****************************************
    wire [`DMSC_MODE_W*2-1:0] modes = {mode2_reg, mode1_reg};
    wire [`DMSC_DRV_W*2-1:0]  drv_next;
    wire [1:0]                load_next;
    wire [1:0]                clamp_next;
    wire [`DMSC_SLEW_W*2-1:0] slew_next;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            wire [`DMSC_MODE_W-1:0] m     = modes[ch*`DMSC_MODE_W +: `DMSC_MODE_W];
            wire                    low_leak_select = m[`DMSC_BIT_LOW_LEAK_SELECT];
            wire                    term  = m[`DMSC_BIT_TERM];
            wire                    load_cal_force = m[`DMSC_BIT_LOAD_CAL_FORCE];
            reg  [`DMSC_DRV_W-1:0]  drv_c;
            reg                     load_c;
            reg                     clamp_c;

            always @* begin
                drv_c   = `DMSC_DRV_LOW_LEAK_SELECT;
                load_c  = 1'b0;
                clamp_c = 1'b0;
                if (low_leak_select) begin
                    // Low leakage wins over load enable and calibrate
                    drv_c   = `DMSC_DRV_LOW_LEAK_SELECT;
                    load_c  = 1'b0;
                    clamp_c = 1'b0;
                end else begin
                    load_c = load_enable_in_s[ch] | load_cal_force;
                    if (!rcv_s[ch]) begin
                        if (data_s[ch])
                            drv_c = `DMSC_DRV_HIGH;
                        else
                            drv_c = `DMSC_DRV_LOW;
                    end else if (term) begin
                        drv_c = `DMSC_DRV_TERM;
                    end else begin
                        // Clamps only in high impedance
                        drv_c   = `DMSC_DRV_HIZ;
                        clamp_c = 1'b1;
                    end
                end
            end

            assign drv_next[ch*`DMSC_DRV_W +: `DMSC_DRV_W]    = drv_c;
            assign load_next[ch]                              = load_c;
            assign clamp_next[ch]                             = clamp_c;
            assign slew_next[ch*`DMSC_SLEW_W +: `DMSC_SLEW_W] =
                m[`DMSC_BIT_SLEW_HI:`DMSC_BIT_SLEW_LO];
        end
    endgenerate

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_chan_one_mode <= `DMSC_MODE_RST;
            o_chan_two_mode <= `DMSC_MODE_RST;
        end else begin
            o_chan_one_mode <= mode1_reg;
            o_chan_two_mode <= mode2_reg;
        end
    end

    // Decoded outputs change in the same cycle as the mode mirrors
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_drive_state <= {`DMSC_DRV_LOW_LEAK_SELECT, `DMSC_DRV_LOW_LEAK_SELECT};
            o_slew_select <= {`DMSC_SLEW_100, `DMSC_SLEW_100};
            o_load_on     <= `DMSC_FLAGS_OFF;
            o_clamp_on    <= `DMSC_FLAGS_OFF;
            o_comp_on     <= `DMSC_FLAGS_OFF;
        end else begin
            o_drive_state <= drv_next;
            // Code 00..11 maps to 100/75/50/25 percent
            o_slew_select <= slew_next;
            o_load_on     <= load_next;
            o_clamp_on    <= clamp_next;
            o_comp_on     <= `DMSC_COMP_ON;
        end
    end

endmodule // dmsc_serial_ctrl
